/* File: bench/pwc_checker_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pwc_checker_properties
	import pwc_pkg::*;
(
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire logic         pix_valid,
	input wire pwc_pix_req_t pix_req,
	input wire logic         pix_ack,
	input wire logic         pix_inhibit,
	input wire logic         pix_abort,
	input wire logic         blk_valid,
	input wire logic         blk_ack,
	input wire logic         outside_flag
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// answers land exactly one edge after the request
	a_pix_ack_lat: assert property (
		pix_valid |=> pix_ack) else $error("pixel ack late");
	a_blk_ack_lat: assert property (
		blk_valid |=> blk_ack) else $error("block ack late");
	// unchecked writes must never be held back
	a_other_pass: assert property (
		pix_valid && pix_req.op == PWC_OP_OTHER |=> !pix_inhibit && !pix_abort)
		else $error("plain write touched");
	a_lin_pass: assert property (
		pix_valid && !pix_req.xy_addr |=> !pix_inhibit && !pix_abort)
		else $error("linear write touched");
	a_lin_flag: assert property (
		pix_valid && !pix_req.xy_addr && !blk_valid |=> $stable(outside_flag))
		else $error("linear write moved flag");
	// only a line may be told to stop, and a stop is never a write
	a_abort_line: assert property (
		pix_abort |-> pix_ack && $past(pix_req.op) == PWC_OP_LINE)
		else $error("abort outside a line");
	a_abort_inh: assert property (
		pix_abort |-> pix_inhibit) else $error("abort without inhibit");
	// the flag only moves on an answered request
	a_flag_cause: assert property (
		!$stable(outside_flag) |-> pix_ack || blk_ack)
		else $error("flag moved on its own");
endmodule

bind pwc_checker pwc_checker_properties pwc_checker_properties_i (
	.aclk, .aresetn, .pix_valid, .pix_req, .pix_ack, .pix_inhibit,
	.pix_abort, .blk_valid, .blk_ack, .outside_flag);
`default_nettype wire

/* File: bench/pwc_checker_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pwc_checker_tb_top import pwc_pkg::*;;
	logic         aclk, aresetn, s_awvalid, s_wvalid, s_bready;
	logic         s_arvalid, s_rready, s_awready, s_wready, s_bvalid;
	logic         s_arready, s_rvalid, pix_valid, pix_ack, pix_inhibit;
	logic         pix_abort, blk_valid, blk_ack, outside_flag, violation_irq;
	logic [31:0]  s_awaddr, s_wdata, s_araddr, s_rdata, d;
	logic [3:0]   s_wstrb;
	logic [2:0]   s_awprot, s_arprot;
	logic [1:0]   s_bresp, s_rresp, rsp;
	pwc_pix_req_t pix_req;
	pwc_blk_req_t blk_req;
	pwc_blk_res_t blk_res, br;
	int           miscompares, n_tests, k;

	pwc_checker pwc_checker_i (
		.aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_awprot,
		.s_wvalid, .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready,
		.s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_arprot, .s_rvalid,
		.s_rready, .s_rdata, .s_rresp, .pix_valid, .pix_req, .pix_ack,
		.pix_inhibit, .pix_abort, .blk_valid, .blk_req, .blk_ack, .blk_res,
		.outside_flag, .violation_irq);
	pwc_engine pwc_engine_i (
		.aclk, .pix_valid, .pix_req, .pix_ack, .pix_inhibit, .pix_abort,
		.blk_valid, .blk_req, .blk_ack, .blk_res);

	// 40 MHz
	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic chk(input logic [127:0] s, input logic [127:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %0t: saw %0h expected %0h", $time, s, e);
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ga, gw;
		ga = 1'h0;
		gw = 1'h0;
		@(posedge aclk);
		s_awaddr <= {24'h0, a};
		s_wdata <= v;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		while (!(ga && gw)) begin
			@(posedge aclk);
			if (!ga && s_awready) begin
				ga = 1'h1;
				s_awvalid <= 1'h0;
			end
			if (!gw && s_wready) begin
				gw = 1'h1;
				s_wvalid <= 1'h0;
			end
		end
		s_bready <= 1'h1;
		do @(posedge aclk); while (!s_bvalid);
		rsp = s_bresp;
		s_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_araddr <= {24'h0, a};
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		do @(posedge aclk); while (!s_arready);
		s_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_rvalid);
		d = s_rdata;
		rsp = s_rresp;
		s_rready <= 1'h0;
	endtask
	task automatic pend(input logic e);
		rd(8'h14);
		chk(d[0], e);
	endtask
	// expectation e is {inhibit, outside flag}
	task automatic p(input pwc_op_t o, input logic xy, input logic [15:0] x,
		input logic [15:0] y, input logic [1:0] e);
		pwc_engine_i.pix({o, xy, x, y});
		chk({pwc_engine_i.ack, pwc_engine_i.inh, outside_flag}, {1'h1, e});
	endtask
	task automatic b(input pwc_blk_req_t q);
		pwc_engine_i.blk(q);
		br = pwc_engine_i.res;
		chk(pwc_engine_i.ack, 1'h1);
	endtask
	// a horizontal line that stops where it is told to
	task automatic line(input logic [15:0] x, input int n);
		for (k = 0; k < n; k++) begin
			pwc_engine_i.pix({PWC_OP_LINE, 1'h1, x + 16'(k), 16'h14});
			if (pwc_engine_i.abt)
				break;
		end
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (40000) @(posedge aclk);
		miscompares++;
		wrap_up;
	end

	initial begin
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{s_awaddr, s_wdata, s_araddr, s_awprot, s_arprot} = '0;
		s_wstrb = 4'hf;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i));
			chk(d, 32'h0);
		end
		rd(8'h18);
		chk({d, rsp}, {32'h0, 2'h2});
		wr(8'h18, 32'h1);
		chk(rsp, 2'h2);
		wr(8'h04, 32'h0014_000a);
		wr(8'h08, 32'h0028_001e);
		chk(rsp, 2'h0);
		rd(8'h08);
		chk(d, 32'h0028_001e);
		fin("registers");
		wr(8'h00, 32'h3);
		p(PWC_OP_DRAW_AND_ADVANCE, 1'h1, 16'ha, 16'h14, 2'h0);
		p(PWC_OP_SINGLE_PIXEL_TRANSFER, 1'h1, 16'h1f, 16'h28, 2'h3);
		p(PWC_OP_SINGLE_PIXEL_TRANSFER, 1'h1, 16'h1e, 16'h28, 2'h0);
		b({PWC_OP_BLOCKXFER, 1'h1, 16'h5, 16'hf, 16'ha, 16'ha, 16'h64, 16'hc8});
		chk({br, outside_flag}, {PWC_ACT_PROCEED, 1'h1, 16'ha, 16'h14,
			16'h5, 16'h5, 16'h69, 16'hcd, 1'h0});
		line(16'h1c, 5);
		chk({k, outside_flag}, {32'd5, 1'h1});
		pend(1'h0);
		fin("clip");
		wr(8'h00, 32'h0);
		p(PWC_OP_DRAW_AND_ADVANCE, 1'h1, 16'hf, 16'h19, 2'h1);
		fin("off");
		wr(8'h00, 32'h1);
		p(PWC_OP_DRAW_AND_ADVANCE, 1'h1, 16'h5, 16'h5, 2'h3);
		pend(1'h0);
		p(PWC_OP_SINGLE_PIXEL_TRANSFER, 1'h1, 16'h1e, 16'h28, 2'h2);
		pend(1'h1);
		wr(8'h10, 32'h1);
		// the request flop updates at the edge that ends the write
		#1;
		chk(violation_irq, 1'h0);
		wr(8'h0c, 32'h2);
		#1;
		chk(violation_irq, 1'h1);
		wr(8'h14, 32'h1);
		pend(1'h0);
		line(16'h5, 10);
		chk({k, outside_flag}, {32'd5, 1'h0});
		pend(1'h1);
		wr(8'h14, 32'h1);
		b({PWC_OP_FILL, 1'h1, 16'h0, 16'h0, 16'hf, 16'h19, 16'h0, 16'h0});
		chk({br[98:32], outside_flag}, {PWC_ACT_SKIP, 1'h1, 16'ha,
			16'h14, 16'h5, 16'h5, 1'h0});
		pend(1'h1);
		fin("hit");
		wr(8'h00, 32'h2);
		wr(8'h14, 32'h1);
		p(PWC_OP_SINGLE_PIXEL_TRANSFER, 1'h1, 16'hf, 16'h19, 2'h0);
		pend(1'h0);
		p(PWC_OP_DRAW_AND_ADVANCE, 1'h1, 16'h0, 16'h19, 2'h3);
		pend(1'h1);
		wr(8'h14, 32'h1);
		line(16'h1c, 5);
		chk({k, outside_flag}, {32'd3, 1'h1});
		wr(8'h14, 32'h1);
		b({PWC_OP_FILL, 1'h1, 16'ha, 16'h14, 16'h15, 16'h15, 16'h0, 16'h0});
		chk({br.act, outside_flag}, {PWC_ACT_PROCEED, 1'h0});
		pend(1'h0);
		b({PWC_OP_FILL, 1'h1, 16'ha, 16'h14, 16'h16, 16'h15, 16'h0, 16'h0});
		chk({br.act, outside_flag}, {PWC_ACT_ABORT, 1'h1});
		pend(1'h1);
		p(PWC_OP_SINGLE_PIXEL_TRANSFER, 1'h1, 16'hf, 16'h19, 2'h0);
		p(PWC_OP_DRAW_AND_ADVANCE, 1'h0, 16'h0, 16'h0, 2'h0);
		p(PWC_OP_OTHER, 1'h1, 16'h0, 16'h0, 2'h0);
		wr(8'h00, 32'h0);
		p(PWC_OP_SINGLE_PIXEL_TRANSFER, 1'h1, 16'h0, 16'h0, 2'h0);
		pend(1'h1);
		fin("miss");
		wr(8'h00, 32'h3);
		wr(8'h04, 32'h0007_0007);
		wr(8'h08, 32'h0007_0007);
		p(PWC_OP_DRAW_AND_ADVANCE, 1'h1, 16'h7, 16'h7, 2'h0);
		p(PWC_OP_DRAW_AND_ADVANCE, 1'h1, 16'h7, 16'h8, 2'h3);
		wr(8'h04, 32'h0007_0008);
		p(PWC_OP_DRAW_AND_ADVANCE, 1'h1, 16'h7, 16'h7, 2'h3);
		fin("window");
		wrap_up;
	end
endmodule
`default_nettype wire

/* File: bench/pwc_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module pwc_engine
	import pwc_pkg::*;
(
	input  wire logic         aclk,
	output var  logic         pix_valid,
	output var  pwc_pix_req_t pix_req,
	input  wire logic         pix_ack,
	input  wire logic         pix_inhibit,
	input  wire logic         pix_abort,
	output var  logic         blk_valid,
	output var  pwc_blk_req_t blk_req,
	input  wire logic         blk_ack,
	input  wire pwc_blk_res_t blk_res
);
	logic         ack, inh, abt;
	pwc_blk_res_t res;
	// nothing offered until an instruction runs
	initial begin
		pix_valid = 1'h0;
		blk_valid = 1'h0;
		pix_req = '0;
		blk_req = '0;
	end
	// one write attempt; the verdict is taken once it has settled
	task automatic pix(input pwc_pix_req_t q);
		@(posedge aclk);
		pix_valid <= 1'h1;
		pix_req <= q;
		@(posedge aclk);
		pix_valid <= 1'h0;
		pix_req <= ~q; // a stale request must not look current
		#1;
		ack = pix_ack;
		inh = pix_inhibit;
		abt = pix_abort;
	endtask
	// block set-up; the next instruction follows whatever the verdict
	task automatic blk(input pwc_blk_req_t q);
		@(posedge aclk);
		blk_valid <= 1'h1;
		blk_req <= q;
		@(posedge aclk);
		blk_valid <= 1'h0;
		blk_req <= ~q;
		#1;
		ack = blk_ack;
		res = blk_res;
	endtask
endmodule
`default_nettype wire

/* File: core/pwc_checker.sv */
// Operation
// - only block, fill, line, draw-advance and pixel-transfer writes are checked
// - inside means min X..max X and min Y..max Y inclusive, corners inside
// - only XY-addressed destinations are checked, linear ones never
// - mode 0 off, 1 hit detect, 2 miss detect, 3 clip
// - modes 1-3: outside write sets outside flag, inside write clears it
// - mode 0 leaves the outside flag unchanged
// - hit mode inhibits every pixel write
// - hit mode block: wholly outside sets flag; any inside clears, sets pending
// - hit mode block returns intersection as new destination, moves no pixels
// - block violation resumes at the following instruction
// - hit mode single pixel: outside sets flag; inside clears, sets pending
// - hit mode line aborts, sets pending at first inside pixel
// - miss mode block runs only wholly inside, else aborts and sets pending
// - miss mode single pixel: inside proceeds; outside suppressed, pending set
// - miss mode line aborts, sets pending at first outside pixel
// - clip mode passes inside writes only and never sets pending
// - clip mode block shrinks destination, and source to match
// - clip mode single pixel: inside proceeds clears; outside suppressed sets
// - clip mode line tests each pixel; flag follows the last pixel
// - window bounds come from min-corner and max-corner registers
// - min above max gives empty window; equal bounds give one pixel
// - interrupt only when pending, its enable and global enable are set
// - aborted instruction keeps its intermediate register values
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pwc_regs.svh"

module pwc_checker
	import pwc_pkg::*;
#(
	parameter int COORD_W = `PWC_CW
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         s_awvalid,
	output var  logic         s_awready,
	input  wire logic [31:0]  s_awaddr,
	input  wire logic [2:0]   s_awprot,
	input  wire logic         s_wvalid,
	output var  logic         s_wready,
	input  wire logic [31:0]  s_wdata,
	input  wire logic [3:0]   s_wstrb,
	output var  logic         s_bvalid,
	input  wire logic         s_bready,
	output var  logic [1:0]   s_bresp,
	input  wire logic         s_arvalid,
	output var  logic         s_arready,
	input  wire logic [31:0]  s_araddr,
	input  wire logic [2:0]   s_arprot,
	output var  logic         s_rvalid,
	input  wire logic         s_rready,
	output var  logic [31:0]  s_rdata,
	output var  logic [1:0]   s_rresp,
	input  wire logic         pix_valid,
	input  wire pwc_pix_req_t pix_req,
	output var  logic         pix_ack,
	output var  logic         pix_inhibit,
	output var  logic         pix_abort,
	input  wire logic         blk_valid,
	input  wire pwc_blk_req_t blk_req,
	output var  logic         blk_ack,
	output var  pwc_blk_res_t blk_res,
	output var  logic         outside_flag,
	output var  logic         violation_irq
);

	// coordinates are packed two to a 32-bit word, so only 16 fits
	if (COORD_W != `PWC_CW) begin : g_bad_width
		$error("pwc_checker: COORD_W must be 16");
	end

	// sign-extend a coordinate so end points and negatives compare safely
	function automatic logic signed [17:0] sx(input logic [15:0] v);
		return $signed({{2{v[15]}}, v});
	endfunction

	// byte-lane merge for AXI write strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] nw,
	                                      input logic [3:0]  strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [1:0]  mode_r;
	logic [31:0] win_min_r;
	logic [31:0] win_max_r;
	logic        gie_r;
	logic        wve_r;
	logic        pend_r;
	logic        aw_full_r;
	logic        w_full_r;
	logic [31:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;

	// ---- window geometry, shared by both request paths
	logic signed [17:0] wx0;
	logic signed [17:0] wx1;
	logic signed [17:0] wy0;
	logic signed [17:0] wy1;
	logic               win_ok;
	assign wx0 = sx(win_min_r[`PWC_X_MSB:`PWC_X_LSB]);
	assign wy0 = sx(win_min_r[`PWC_Y_MSB:`PWC_Y_LSB]);
	assign wx1 = sx(win_max_r[`PWC_X_MSB:`PWC_X_LSB]);
	assign wy1 = sx(win_max_r[`PWC_Y_MSB:`PWC_Y_LSB]);
	// inverted bounds make every pixel outside; equal bounds keep one
	assign win_ok = (wx0 <= wx1) && (wy0 <= wy1);

	// ---- single pixel path
	logic signed [17:0] px;
	logic signed [17:0] py;
	logic               pix_gop;
	logic               pix_chk;
	logic               pix_in;
	logic               pix_line;
	assign px = sx(pix_req.x);
	assign py = sx(pix_req.y);
	assign pix_gop = pix_req.op != PWC_OP_OTHER;
	assign pix_chk = pix_valid && pix_gop && pix_req.xy_addr
	              && mode_r != `PWC_MODE_OFF;
	assign pix_in = win_ok && px >= wx0 && px <= wx1
	             && py >= wy0 && py <= wy1;
	assign pix_line = pix_req.op == PWC_OP_LINE;

	logic pix_inh_nxt;
	logic pix_abt_nxt;
	logic pix_pend;
	// hit mode blocks all writes; miss and clip block outside writes
	assign pix_inh_nxt = pix_chk && (mode_r == `PWC_MODE_HIT
	                  || !pix_in);
	// pending on inside hit or outside miss; clip never raises it
	assign pix_pend = pix_chk
	               && ((mode_r == `PWC_MODE_HIT && pix_in)
	               || (mode_r == `PWC_MODE_MISS && !pix_in));
	// a line stops on the same pixel that raised the violation
	assign pix_abt_nxt = pix_pend && pix_line;

	// ---- block transfer / fill path
	logic               blk_chk;
	logic               blk_empty;
	logic               blk_any;
	logic               blk_all;
	logic signed [17:0] dx0;
	logic signed [17:0] dx1;
	logic signed [17:0] dy0;
	logic signed [17:0] dy1;
	logic signed [17:0] ix0;
	logic signed [17:0] ix1;
	logic signed [17:0] iy0;
	logic signed [17:0] iy1;
	assign blk_chk = blk_valid && blk_req.xy_addr
	              && (blk_req.op == PWC_OP_BLOCKXFER
	              || blk_req.op == PWC_OP_FILL)
	              && mode_r != `PWC_MODE_OFF;
	assign blk_empty = blk_req.width == 16'h0000
	                || blk_req.height == 16'h0000;
	assign dx0 = sx(blk_req.dst_x);
	assign dy0 = sx(blk_req.dst_y);
	assign dx1 = dx0 + $signed({2'b00, blk_req.width}) - $signed(`PWC_ONE18);
	assign dy1 = dy0 + $signed({2'b00, blk_req.height}) - $signed(`PWC_ONE18);
	// intersection of destination rectangle and window
	assign ix0 = (dx0 > wx0) ? dx0 : wx0;
	assign ix1 = (dx1 < wx1) ? dx1 : wx1;
	assign iy0 = (dy0 > wy0) ? dy0 : wy0;
	assign iy1 = (dy1 < wy1) ? dy1 : wy1;
	assign blk_any = win_ok && !blk_empty
	              && ix0 <= ix1 && iy0 <= iy1;
	assign blk_all = win_ok && !blk_empty && dx0 >= wx0
	              && dx1 <= wx1 && dy0 >= wy0 && dy1 <= wy1;

	logic signed [17:0] iw;
	logic signed [17:0] ih;
	logic signed [17:0] sxo;
	logic signed [17:0] syo;
	assign iw  = ix1 - ix0 + $signed(`PWC_ONE18);
	assign ih  = iy1 - iy0 + $signed(`PWC_ONE18);
	// source follows the same shift as the clipped destination
	assign sxo = sx(blk_req.src_x) + (ix0 - dx0);
	assign syo = sx(blk_req.src_y) + (iy0 - dy0);

	pwc_blk_res_t clip_res;
	pwc_blk_res_t pass_res;
	pwc_blk_res_t blk_nxt;
	pwc_act_t     blk_act;
	logic         blk_upd;
	logic         blk_pend;
	logic         blk_out;
	assign clip_res = '{act: PWC_ACT_PROCEED, update: 1'b1,
	                    dst_x: ix0[15:0], dst_y: iy0[15:0],
	                    width: blk_any ? iw[15:0] : 16'h0000,
	                    height: blk_any ? ih[15:0] : 16'h0000,
	                    src_x: sxo[15:0], src_y: syo[15:0]};
	assign pass_res = '{act: PWC_ACT_PROCEED, update: 1'b0,
	                    dst_x: blk_req.dst_x, dst_y: blk_req.dst_y,
	                    width: blk_req.width, height: blk_req.height,
	                    src_x: blk_req.src_x, src_y: blk_req.src_y};
	// hit mode never moves pixels; clip skips when nothing is left
	// aborted miss keeps its registers as they were at detection
	assign blk_act = !blk_chk ? PWC_ACT_PROCEED
	    : (mode_r == `PWC_MODE_HIT) ? PWC_ACT_SKIP
	    : (mode_r == `PWC_MODE_MISS)
	        ? (blk_all ? PWC_ACT_PROCEED : PWC_ACT_ABORT)
	    : (blk_any ? PWC_ACT_PROCEED : PWC_ACT_SKIP);
	assign blk_upd = blk_chk && (mode_r == `PWC_MODE_HIT
	              || mode_r == `PWC_MODE_CLIP);
	assign blk_pend = blk_chk
	               && ((mode_r == `PWC_MODE_HIT && blk_any)
	               || (mode_r == `PWC_MODE_MISS && !blk_all));
	assign blk_out = (mode_r == `PWC_MODE_MISS) ? !blk_all : !blk_any;
	always_comb begin
		blk_nxt = blk_upd ? clip_res : pass_res;
		blk_nxt.act = blk_act;
		blk_nxt.update = blk_upd;
	end

	// ---- outside flag: last checked write wins, mode 0 leaves it
	logic out_nxt;
	assign out_nxt = pix_chk ? !pix_in
	              : blk_chk ? blk_out
	              : outside_flag;

	// ---- AXI4-Lite write channel
	logic aw_take, w_take, wr_do, aw_full_nxt, w_full_nxt, bvalid_nxt;
	assign aw_take = s_awvalid && s_awready;
	assign w_take  = s_wvalid && s_wready;
	assign wr_do   = aw_full_r && w_full_r && !s_bvalid;
	assign aw_full_nxt = (aw_full_r || aw_take) && !wr_do;
	assign w_full_nxt  = (w_full_r || w_take) && !wr_do;
	assign bvalid_nxt  = wr_do || (s_bvalid && !s_bready);

	logic wr_ctl, wr_min, wr_max, wr_sta, wr_enb, wr_pnd, wr_hit;
	assign wr_ctl = wr_do && awaddr_r == `PWC_OFF_CONTROL;
	assign wr_min = wr_do && awaddr_r == `PWC_OFF_WIN_MIN;
	assign wr_max = wr_do && awaddr_r == `PWC_OFF_WIN_MAX;
	assign wr_sta = wr_do && awaddr_r == `PWC_OFF_STATUS;
	assign wr_enb = wr_do && awaddr_r == `PWC_OFF_INT_ENB;
	assign wr_pnd = wr_do && awaddr_r == `PWC_OFF_INT_PEND;
	assign wr_hit = wr_ctl || wr_min || wr_max
	             || wr_sta || wr_enb || wr_pnd;

	logic [31:0] mrg;
	logic [31:0] ctl_mrg;
	logic        pend_clr;
	logic        pend_nxt;
	assign mrg = merge(32'h0000_0000, wdata_r, wstrb_r);
	// mode lives in byte lane 0; a call result cannot be sliced in place
	assign ctl_mrg = merge({30'h0, mode_r}, wdata_r, wstrb_r);
	// write-one-to-clear; a violation in the same cycle wins
	assign pend_clr = wr_pnd && mrg[`PWC_PEND_WVP_BIT];
	assign pend_nxt = pix_pend || blk_pend
	               || (pend_r && !pend_clr);

	// ---- AXI4-Lite read channel
	logic        ar_take, rvalid_nxt;
	logic [31:0] rd_word;
	logic        rd_hit;
	assign ar_take = s_arvalid && s_arready;
	assign rvalid_nxt = ar_take || (s_rvalid && !s_rready);
	assign rd_hit = s_araddr == `PWC_OFF_CONTROL
	             || s_araddr == `PWC_OFF_WIN_MIN
	             || s_araddr == `PWC_OFF_WIN_MAX
	             || s_araddr == `PWC_OFF_STATUS
	             || s_araddr == `PWC_OFF_INT_ENB
	             || s_araddr == `PWC_OFF_INT_PEND;
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (s_araddr)
		`PWC_OFF_CONTROL: rd_word[`PWC_MODE_MSB:`PWC_MODE_LSB] = mode_r;
		`PWC_OFF_WIN_MIN: rd_word = win_min_r;
		`PWC_OFF_WIN_MAX: rd_word = win_max_r;
		`PWC_OFF_STATUS: begin
			rd_word[`PWC_STAT_OUT_BIT] = outside_flag;
			rd_word[`PWC_STAT_GIE_BIT] = gie_r;
		end
		`PWC_OFF_INT_ENB: rd_word[`PWC_ENB_WVE_BIT] = wve_r;
		`PWC_OFF_INT_PEND: rd_word[`PWC_PEND_WVP_BIT] = pend_r;
		default: rd_word = 32'h0000_0000;
		endcase
	end

	// bus handshake state; ready is withheld while a slot is full
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			s_awready <= !aw_full_nxt && !bvalid_nxt;
			s_wready  <= !w_full_nxt && !bvalid_nxt;
			s_bvalid  <= bvalid_nxt;
			s_arready <= !rvalid_nxt;
			s_rvalid  <= rvalid_nxt;
		end
	end

	// bus payload holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= 32'h0000_0000;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
			s_bresp  <= `PWC_RESP_OKAY;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= `PWC_RESP_OKAY;
		end else begin
			if (aw_take) awaddr_r <= s_awaddr;
			if (w_take) begin
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_do) s_bresp <= wr_hit ? `PWC_RESP_OKAY : `PWC_RESP_SLVERR;
			if (ar_take) begin
				s_rdata <= rd_word;
				s_rresp <= rd_hit ? `PWC_RESP_OKAY : `PWC_RESP_SLVERR;
			end
		end
	end

	// software-visible configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r    <= `PWC_RST_MODE;
			win_min_r <= `PWC_RST_CORNER;
			win_max_r <= `PWC_RST_CORNER;
			gie_r     <= `PWC_RST_BIT;
			wve_r     <= `PWC_RST_BIT;
		end else begin
			if (wr_ctl) begin
				mode_r <= ctl_mrg[`PWC_MODE_MSB:`PWC_MODE_LSB];
			end
			if (wr_min) win_min_r <= merge(win_min_r, wdata_r, wstrb_r);
			if (wr_max) win_max_r <= merge(win_max_r, wdata_r, wstrb_r);
			if (wr_sta && wstrb_r[0]) gie_r <= wdata_r[`PWC_STAT_GIE_BIT];
			if (wr_enb && wstrb_r[0]) wve_r <= wdata_r[`PWC_ENB_WVE_BIT];
		end
	end

	// checker answers, one cycle after each request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pix_ack       <= 1'b0;
			pix_inhibit   <= 1'b0;
			pix_abort     <= 1'b0;
			blk_ack       <= 1'b0;
			blk_res       <= '0;
			outside_flag  <= `PWC_RST_BIT;
			pend_r        <= `PWC_RST_BIT;
			violation_irq <= 1'b0;
		end else begin
			pix_ack       <= pix_valid;
			pix_inhibit   <= pix_inh_nxt;
			pix_abort     <= pix_abt_nxt;
			blk_ack       <= blk_valid;
			blk_res       <= blk_nxt;
			outside_flag  <= out_nxt;
			pend_r        <= pend_nxt;
			violation_irq <= pend_nxt && wve_r && gie_r;
		end
	end

endmodule
`default_nettype wire

/* File: core/pwc_pkg.sv */
package pwc_pkg;

	// graphics instruction issuing the request
	typedef enum logic [2:0] {
		PWC_OP_OTHER,
		PWC_OP_BLOCKXFER,
		PWC_OP_FILL,
		PWC_OP_LINE,
		PWC_OP_DRAW_AND_ADVANCE,
		PWC_OP_SINGLE_PIXEL_TRANSFER
	} pwc_op_t;

	// what the engine does with a block transfer or fill
	typedef enum logic [1:0] {
		PWC_ACT_PROCEED,
		PWC_ACT_SKIP,
		PWC_ACT_ABORT
	} pwc_act_t;

	typedef struct packed {
		pwc_op_t     op;
		logic        xy_addr;
		logic [15:0] x;
		logic [15:0] y;
	} pwc_pix_req_t;

	typedef struct packed {
		pwc_op_t     op;
		logic        xy_addr;
		logic [15:0] dst_x;
		logic [15:0] dst_y;
		logic [15:0] width;
		logic [15:0] height;
		logic [15:0] src_x;
		logic [15:0] src_y;
	} pwc_blk_req_t;

	typedef struct packed {
		pwc_act_t    act;
		logic        update;
		logic [15:0] dst_x;
		logic [15:0] dst_y;
		logic [15:0] width;
		logic [15:0] height;
		logic [15:0] src_x;
		logic [15:0] src_y;
	} pwc_blk_res_t;

endpackage

/* File: core/pwc_regs.svh */
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

// register byte offsets on the AXI4-Lite bus
`define PWC_OFF_CONTROL   32'h0000_0000
`define PWC_OFF_WIN_MIN   32'h0000_0004
`define PWC_OFF_WIN_MAX   32'h0000_0008
`define PWC_OFF_STATUS    32'h0000_000c
`define PWC_OFF_INT_ENB   32'h0000_0010
`define PWC_OFF_INT_PEND  32'h0000_0014

// field positions
`define PWC_MODE_LSB      0
`define PWC_MODE_MSB      1
`define PWC_X_LSB         0
`define PWC_X_MSB         15
`define PWC_Y_LSB         16
`define PWC_Y_MSB         31
`define PWC_STAT_OUT_BIT  0
`define PWC_STAT_GIE_BIT  1
`define PWC_ENB_WVE_BIT   0
`define PWC_PEND_WVP_BIT  0

// checking modes
`define PWC_MODE_OFF      2'h0
`define PWC_MODE_HIT      2'h1
`define PWC_MODE_MISS     2'h2
`define PWC_MODE_CLIP     2'h3

// reset values
`define PWC_RST_MODE      2'h0
`define PWC_RST_CORNER    32'h0000_0000
`define PWC_RST_BIT       1'h0

// bus answers and widths
`define PWC_RESP_OKAY     2'h0
`define PWC_RESP_SLVERR   2'h2
`define PWC_CW            16
`define PWC_ONE18         18'h0_0001

`endif
